//--- rtl/qvs_sequencer.sv
// Quasi-resonant valley switch sequencer with register port and interrupt
`timescale 1ns/1ps
module qvs_sequencer #(
    parameter int unsigned AUX_CYC = qvs_pkg::AUX_SHORT_CYC,
    parameter int unsigned LINE_CYC = qvs_pkg::LINE_BLANK_CYC,
    parameter int unsigned REC_CYC = qvs_pkg::RECOVERY_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Analog front end comparators
    input wire logic run_ok_i,
    input wire logic cs_above_setpoint_i,
    input wire logic zc_below_valley_i,
    input wire logic zc_above_arm_i,
    input wire logic zc_above_short_i,
    input wire logic line_below_low_i,
    input wire logic line_above_high_i,
    input wire logic ota_sinking_i,
    // Power stage controls
    output logic gate_drive_out_o,
    output logic sense_ground_o,
    output logic comp_ground_o,
    output logic comp_boost_o,
    output logic high_line_flag_o,
    output logic gain_half_o,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o
);

    localparam int TW = qvs_pkg::TIMER_W;

    typedef struct packed {
        qvs_pkg::qvs_state_type st;
        logic gate;
        logic [TW-1:0] timer;
        logic [TW-1:0] low_time;
        logic [qvs_pkg::GND_W-1:0] gnd_cnt;
        logic start_blank;
        logic boost;
        logic armed;
        logic demag;
        logic valley_prev;
        logic high_line;
        logic [31:0] low_cnt;
        logic [31:0] aux_cnt;
        logic [31:0] rec_cnt;
        logic ctrl_en;
        logic [qvs_pkg::IRQ_W-1:0] irq_stat;
        logic [qvs_pkg::IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
    } qvs_regs_type;

    qvs_regs_type r_reg;
    qvs_regs_type r_next;
    logic [qvs_pkg::IN_W-1:0] raw_vec;
    logic [qvs_pkg::IN_W-1:0] s;
    logic run;
    logic valley_edge;
    logic blank_done;
    logic aux_hit;
    logic [TW-1:0] blank_lim;
    logic [TW-1:0] wd_lim;

    // ==========================================================
    // Input synchronisation
    assign raw_vec = {ota_sinking_i, line_above_high_i, line_below_low_i, zc_above_short_i,
                      zc_above_arm_i, zc_below_valley_i, cs_above_setpoint_i, run_ok_i};

    qvs_sync #(
        .W(qvs_pkg::IN_W)
    ) u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .async_i(raw_vec),
        .sync_o(s)
    );

    assign run = s[qvs_pkg::IN_RUN] & r_reg.ctrl_en;
    assign valley_edge = s[qvs_pkg::IN_VALLEY] & ~r_reg.valley_prev;
    assign blank_lim = r_reg.start_blank ? qvs_pkg::START_BLANK_CYC
                                         : qvs_pkg::NOM_BLANK_CYC;
    assign wd_lim = r_reg.high_line ? qvs_pkg::WD_HIGH_CYC : qvs_pkg::WD_LOW_CYC;
    assign blank_done = r_reg.timer >= blank_lim;
    assign aux_hit = r_reg.aux_cnt == 32'(AUX_CYC - 1);

    // ==========================================================
    // Next state
    always_comb begin
        logic [qvs_pkg::IRQ_W-1:0] ev;
        logic [qvs_pkg::IRQ_W-1:0] clr;
        logic [31:0] status;
        logic start;
        r_next = r_reg;
        ev = '0;
        clr = '0;
        status = '0;
        start = 1'b0;
        r_next.valley_prev = s[qvs_pkg::IN_VALLEY];
        if (r_reg.gnd_cnt != '0) begin
            r_next.gnd_cnt = r_reg.gnd_cnt - 1'b1;
        end

        // Line range: rising edge immediate, falling side waits out the blanking
        if (s[qvs_pkg::IN_HIGH]) begin
            r_next.high_line = 1'b1;
            r_next.low_cnt = '0;
            ev[qvs_pkg::IRQ_HIGH] = ~r_reg.high_line;
        end else if (s[qvs_pkg::IN_LOW]) begin
            if (r_reg.low_cnt == 32'(LINE_CYC - 1)) begin
                r_next.high_line = 1'b0;
                ev[qvs_pkg::IRQ_LOW] = r_reg.high_line;
            end else begin
                r_next.low_cnt = r_reg.low_cnt + 32'h0000_0001;
            end
        end else begin
            r_next.low_cnt = '0;
        end

        if (s[qvs_pkg::IN_OTA]) begin
            r_next.boost = 1'b0;
        end

        unique case (r_reg.st)
            qvs_pkg::QVS_IDLE: begin
                if (run) begin
                    r_next.st = qvs_pkg::QVS_OFF;
                    r_next.timer = '0;
                    r_next.start_blank = 1'b1;
                    r_next.boost = 1'b1;
                    r_next.armed = 1'b0;
                    r_next.demag = 1'b0;
                    r_next.aux_cnt = '0;
                end
            end
            qvs_pkg::QVS_ON: begin
                // Current comparator ignored while the pin is still grounded
                if (r_reg.gnd_cnt == '0 && s[qvs_pkg::IN_CS]) begin
                    r_next.gate = 1'b0;
                    r_next.st = qvs_pkg::QVS_OFF;
                    r_next.gnd_cnt = qvs_pkg::FALL_GROUND_CYC;
                    r_next.timer = '0;
                    r_next.low_time = '0;
                    r_next.armed = 1'b0;
                    r_next.demag = 1'b0;
                end
            end
            qvs_pkg::QVS_OFF: begin
                // Saturate at the limit; a line change may lower it under the count
                if (r_reg.timer < wd_lim) begin
                    r_next.timer = r_reg.timer + 1'b1;
                end
                if (s[qvs_pkg::IN_ARM]) begin
                    r_next.start_blank = 1'b0;
                end
                if (blank_done) begin
                    if (s[qvs_pkg::IN_ARM]) begin
                        r_next.armed = 1'b1;
                    end
                    if (valley_edge && r_reg.armed) begin
                        if (!r_reg.high_line || r_reg.demag) begin
                            start = 1'b1;
                        end else begin
                            r_next.demag = 1'b1;
                        end
                    end
                    if (r_reg.high_line && r_reg.demag && s[qvs_pkg::IN_VALLEY]) begin
                        r_next.low_time = r_reg.low_time + 1'b1;
                        if (r_reg.low_time == qvs_pkg::TIMEOUT_CYC - 1'b1) begin
                            start = 1'b1;
                            ev[qvs_pkg::IRQ_TIMEOUT] = 1'b1;
                        end
                    end else begin
                        r_next.low_time = '0;
                    end
                end
                if (r_reg.timer >= wd_lim && !start) begin
                    start = 1'b1;
                    ev[qvs_pkg::IRQ_WATCHDOG] = 1'b1;
                end
                if (start) begin
                    r_next.st = qvs_pkg::QVS_ON;
                    r_next.gate = 1'b1;
                    r_next.gnd_cnt = qvs_pkg::RISE_GROUND_CYC;
                end
            end
            qvs_pkg::QVS_FAULT: begin
                if (r_reg.rec_cnt == 32'(REC_CYC - 1)) begin
                    r_next.st = qvs_pkg::QVS_IDLE;
                end else begin
                    r_next.rec_cnt = r_reg.rec_cnt + 32'h0000_0001;
                end
            end
        endcase

        // Aux short timer runs while switching
        if (r_reg.st == qvs_pkg::QVS_ON || r_reg.st == qvs_pkg::QVS_OFF) begin
            if (r_reg.st == qvs_pkg::QVS_OFF && blank_done && s[qvs_pkg::IN_SHORT]) begin
                r_next.aux_cnt = '0;
            end else if (aux_hit) begin
                r_next.st = qvs_pkg::QVS_FAULT;
                r_next.gate = 1'b0;
                r_next.rec_cnt = '0;
                r_next.aux_cnt = '0;
                ev[qvs_pkg::IRQ_FAULT] = 1'b1;
            end else begin
                r_next.aux_cnt = r_reg.aux_cnt + 32'h0000_0001;
            end
        end

        // Supply fault or software disable stops switching and fault recovery at once
        if (!run) begin
            r_next.st = qvs_pkg::QVS_IDLE;
            r_next.gate = 1'b0;
        end

        // Every falling gate edge grounds the pin, fault and stop included
        if (r_reg.gate && !r_next.gate) begin
            r_next.gnd_cnt = qvs_pkg::FALL_GROUND_CYC;
        end

        // Register port
        if (wr_i) begin
            unique case (addr_i)
                qvs_pkg::REG_CTRL: r_next.ctrl_en = wdata_i[qvs_pkg::CTRL_EN_BIT];
                qvs_pkg::REG_IRQ_EN: r_next.irq_en = wdata_i[qvs_pkg::IRQ_W-1:0];
                qvs_pkg::REG_IRQ_CLR: clr = wdata_i[qvs_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // A new event wins over a simultaneous clear
        r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;

        status[qvs_pkg::STAT_HIGH_BIT] = r_reg.high_line;
        status[qvs_pkg::STAT_FAULT_BIT] = r_reg.st == qvs_pkg::QVS_FAULT;
        status[qvs_pkg::STAT_RUN_BIT] = r_reg.st == qvs_pkg::QVS_ON || r_reg.st == qvs_pkg::QVS_OFF;
        status[qvs_pkg::STAT_BLANK_BIT] = r_reg.start_blank;
        status[qvs_pkg::STAT_BOOST_BIT] = r_reg.boost;
        r_next.rdata = '0;
        if (rd_i) begin
            unique case (addr_i)
                qvs_pkg::REG_CTRL: r_next.rdata[qvs_pkg::CTRL_EN_BIT] = r_reg.ctrl_en;
                qvs_pkg::REG_STATUS: r_next.rdata = status;
                qvs_pkg::REG_IRQ_STAT: r_next.rdata[qvs_pkg::IRQ_W-1:0] = r_reg.irq_stat;
                qvs_pkg::REG_IRQ_EN: r_next.rdata[qvs_pkg::IRQ_W-1:0] = r_reg.irq_en;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r_reg <= '0;
            r_reg.st <= qvs_pkg::QVS_IDLE;
            r_reg.ctrl_en <= qvs_pkg::CTRL_EN_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs
    assign gate_drive_out_o = r_reg.gate;
    assign sense_ground_o = r_reg.gnd_cnt != '0;
    assign comp_ground_o = r_reg.st == qvs_pkg::QVS_IDLE || r_reg.st == qvs_pkg::QVS_FAULT;
    assign comp_boost_o = r_reg.boost & ~comp_ground_o;
    assign high_line_flag_o = r_reg.high_line;
    assign gain_half_o = r_reg.high_line;
    assign rdata_o = r_reg.rdata;
    assign irq_o = |(r_reg.irq_stat & r_reg.irq_en);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_comp_ground;
        !run |=> comp_ground_o && !gate_drive_out_o && !comp_boost_o;
    endproperty
    a_comp_ground: assert property (p_comp_ground) else $error("comp node not grounded");

    property p_boost_off;
        comp_boost_o && s[qvs_pkg::IN_OTA] |=> !comp_boost_o;
    endproperty
    a_boost_off: assert property (p_boost_off) else $error("boost kept after sink");

    property p_gate_end;
        r_reg.st == qvs_pkg::QVS_ON && !sense_ground_o && s[qvs_pkg::IN_CS] |=> !gate_drive_out_o;
    endproperty
    a_gate_end: assert property (p_gate_end) else $error("gate not ended");

    property p_valley_low;
        r_reg.st == qvs_pkg::QVS_OFF && blank_done && valley_edge && r_reg.armed
            && !r_reg.high_line && run && !aux_hit |=> gate_drive_out_o;
    endproperty
    a_valley_low: assert property (p_valley_low) else $error("valley missed");

    property p_watchdog;
        r_reg.st == qvs_pkg::QVS_OFF && r_reg.timer >= wd_lim && run && !aux_hit
            |=> gate_drive_out_o;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog missed");

    property p_blank;
        r_reg.st == qvs_pkg::QVS_OFF && r_reg.timer < blank_lim |=> !gate_drive_out_o;
    endproperty
    a_blank: assert property (p_blank) else $error("start inside blanking");

    property p_fault;
        r_reg.st != qvs_pkg::QVS_FAULT ##1 r_reg.st == qvs_pkg::QVS_FAULT
            |-> $past(r_reg.aux_cnt) == 32'(AUX_CYC - 1) && !gate_drive_out_o;
    endproperty
    a_fault: assert property (p_fault) else $error("bad fault entry");

    property p_fall_ground;
        $fell(gate_drive_out_o) |-> sense_ground_o ##12 sense_ground_o ##1 !sense_ground_o;
    endproperty
    a_fall_ground: assert property (p_fall_ground) else $error("fall grounding wrong");

    property p_rise_ground;
        $rose(gate_drive_out_o) |-> sense_ground_o [*7] ##1 !sense_ground_o;
    endproperty
    a_rise_ground: assert property (p_rise_ground) else $error("rise grounding wrong");

    property p_low_line;
        $fell(high_line_flag_o) |-> $past(r_reg.low_cnt) == 32'(LINE_CYC - 1);
    endproperty
    a_low_line: assert property (p_low_line) else $error("low line too early");

    property p_high_line;
        s[qvs_pkg::IN_HIGH] |=> high_line_flag_o && gain_half_o;
    endproperty
    a_high_line: assert property (p_high_line) else $error("high line late");

endmodule : qvs_sequencer

//--- common/qvs_pkg.sv
// Shared constants and types for the valley-switch sequencer
package qvs_pkg;

    // ==========================================================
    // Clock
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;

    // ==========================================================
    // Documented times, each in its own unit
    localparam int WD_LOW_NS = 55000;
    localparam int WD_HIGH_NS = 62000;
    localparam int TIMEOUT_NS = 7300;
    localparam int START_BLANK_NS = 3000;
    localparam int NOM_BLANK_NS = 1500;
    localparam int FALL_GROUND_NS = 325;
    localparam int RISE_GROUND_NS = 175;
    localparam int AUX_SHORT_MS = 90;
    localparam int LINE_BLANK_MS = 25;
    localparam int RECOVERY_S = 4;

    function automatic int cyc_ceil(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : cyc_ceil

    // ==========================================================
    // Cycle counts
    localparam int TIMER_W = 12;
    localparam int GND_W = 4;
    localparam logic [TIMER_W-1:0] WD_LOW_CYC = TIMER_W'(cyc_ceil(WD_LOW_NS));
    localparam logic [TIMER_W-1:0] WD_HIGH_CYC = TIMER_W'(cyc_ceil(WD_HIGH_NS));
    localparam logic [TIMER_W-1:0] TIMEOUT_CYC = TIMER_W'(cyc_ceil(TIMEOUT_NS));
    localparam logic [TIMER_W-1:0] START_BLANK_CYC = TIMER_W'(cyc_ceil(START_BLANK_NS));
    localparam logic [TIMER_W-1:0] NOM_BLANK_CYC = TIMER_W'(cyc_ceil(NOM_BLANK_NS));
    localparam logic [GND_W-1:0] FALL_GROUND_CYC = GND_W'(cyc_ceil(FALL_GROUND_NS));
    localparam logic [GND_W-1:0] RISE_GROUND_CYC = GND_W'(cyc_ceil(RISE_GROUND_NS));
    localparam int unsigned AUX_SHORT_CYC = AUX_SHORT_MS * (CLK_HZ / 1000);
    localparam int unsigned LINE_BLANK_CYC = LINE_BLANK_MS * (CLK_HZ / 1000);
    localparam int unsigned RECOVERY_CYC = RECOVERY_S * CLK_HZ;

    // ==========================================================
    // Synchronised comparator inputs, bit positions
    localparam int IN_RUN = 0;
    localparam int IN_CS = 1;
    localparam int IN_VALLEY = 2;
    localparam int IN_ARM = 3;
    localparam int IN_SHORT = 4;
    localparam int IN_LOW = 5;
    localparam int IN_HIGH = 6;
    localparam int IN_OTA = 7;
    localparam int IN_W = 8;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_EN = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLR = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int STAT_HIGH_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int STAT_BLANK_BIT = 3;
    localparam int STAT_BOOST_BIT = 4;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_HIGH = 1;
    localparam int IRQ_LOW = 2;
    localparam int IRQ_WATCHDOG = 3;
    localparam int IRQ_TIMEOUT = 4;
    localparam int IRQ_W = 5;

    typedef enum logic [1:0] {
        QVS_IDLE,
        QVS_ON,
        QVS_OFF,
        QVS_FAULT
    } qvs_state_type;

endpackage : qvs_pkg

//--- rtl/qvs_sync.sv
// Two-flop synchroniser for the comparator inputs
`timescale 1ns/1ps
module qvs_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } qvs_sync_regs_type;

    qvs_sync_regs_type r_reg;
    qvs_sync_regs_type r_next;

    always_comb begin
        r_next.meta = async_i;
        r_next.stable = r_reg.meta;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sync_o = r_reg.stable;

endmodule : qvs_sync

//--- verif/qvs_power_stage.sv
// Behavioural power stage: switch current ramp and auxiliary winding ringing
`timescale 1ns/1ps
module qvs_power_stage #(
    parameter int ON_CYC = 20,
    parameter int DEMAG_CYC = 200,
    parameter int RING_CYC = 40
) (
    // Clock
    input wire logic mclk_i,
    // From the controller
    input wire logic gate_i,
    input wire logic sense_ground_i,
    input wire logic [1:0] mode_i,
    // Comparator levels
    output logic cs_above_o,
    output logic zc_below_o,
    output logic zc_arm_o,
    output logic zc_short_o
);
    // ==========================================================
    // Time since the last gate edge
    int on_cnt = 0;
    int off_cnt = 0;
    logic ring_low;

    always @(posedge mclk_i) begin
        on_cnt <= gate_i ? on_cnt + 1 : 0;
        off_cnt <= gate_i ? 0 : off_cnt + 1;
    end

    // ==========================================================
    // Pin levels: mode 0 rings, 1 damped after one valley, 2 aux shorted
    always_comb begin
        ring_low = ((off_cnt - DEMAG_CYC) % RING_CYC) < (RING_CYC / 2);
        cs_above_o = gate_i && !sense_ground_i && on_cnt >= ON_CYC;
        zc_below_o = !gate_i;
        zc_arm_o = 1'b0;
        zc_short_o = 1'b0;
        // Grounded pin reads as a valley level while the gate is off, never as an arm or short
        if (!gate_i && !sense_ground_i && mode_i != 2'h2) begin
            if (off_cnt < DEMAG_CYC) begin
                zc_below_o = 1'b0;
                zc_arm_o = 1'b1;
                zc_short_o = 1'b1;
            end else if (mode_i == 2'h0 && !ring_low) begin
                zc_below_o = 1'b0;
                zc_arm_o = 1'b1;
            end
        end
    end
endmodule : qvs_power_stage

//--- verif/testbench.sv
// Self-checking bench for the valley-switch sequencer
`timescale 1ns/1ps
module testbench;
    // ==========================================================
    // Signals
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic run_ok_i = 1'b0;
    logic ota_sinking_i = 1'b0;
    logic line_below_low_i = 1'b1;
    logic line_above_high_i = 1'b0;
    logic [1:0] far_mode = 2'h0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cs_above, zc_below, zc_arm, zc_short;
    logic gate_drive_out_o, sense_ground_o, comp_ground_o, comp_boost_o;
    logic high_line_flag_o, gain_half_o, irq_o;
    logic [31:0] rdata_o;
    int n_errors = 0;
    int n_checks = 0;

    typedef struct packed {
        logic [1:0] mode;
        logic high;
        logic [15:0] lo;
    } qvs_row_type;

    // Far-side mode, line range, earliest off time (10-cycle window)
    qvs_row_type rows [5] = '{
        '{2'h0, 1'b0, 16'h00C8},
        '{2'h2, 1'b0, 16'h0898},
        '{2'h0, 1'b1, 16'h00F0},
        '{2'h1, 1'b1, 16'h01EC},
        '{2'h2, 1'b1, 16'h09B0}
    };

    qvs_sequencer #(.AUX_CYC(6000), .LINE_CYC(100), .REC_CYC(300)) DUT (
        .mclk_i(mclk_i), .reset_i(reset_i), .run_ok_i(run_ok_i),
        .cs_above_setpoint_i(cs_above), .zc_below_valley_i(zc_below),
        .zc_above_arm_i(zc_arm), .zc_above_short_i(zc_short),
        .line_below_low_i(line_below_low_i), .line_above_high_i(line_above_high_i),
        .ota_sinking_i(ota_sinking_i), .gate_drive_out_o(gate_drive_out_o),
        .sense_ground_o(sense_ground_o), .comp_ground_o(comp_ground_o),
        .comp_boost_o(comp_boost_o), .high_line_flag_o(high_line_flag_o),
        .gain_half_o(gain_half_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o)
    );

    qvs_power_stage u_stage (
        .mclk_i(mclk_i), .gate_i(gate_drive_out_o), .sense_ground_i(sense_ground_o),
        .mode_i(far_mode), .cs_above_o(cs_above), .zc_below_o(zc_below),
        .zc_arm_o(zc_arm), .zc_short_o(zc_short)
    );

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // Sample just after the edge so registered outputs have settled
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cycles

    task automatic wait_gate(input logic lvl, output int n);
        n = 0;
        while (gate_drive_out_o !== lvl && n < 5000) begin
            cycles(1);
            n++;
        end
        check(32'(n < 5000), 32'h1);
    endtask : wait_gate

    task automatic count_ground(output int n);
        n = 0;
        while (sense_ground_o === 1'b1 && n < 100) begin
            cycles(1);
            n++;
        end
    endtask : count_ground

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : bus_read

    // ==========================================================
    // Main sequence
    initial begin : main
        int t_off, t_on, g_fall, g_rise, n;
        logic [31:0] d;
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        check(comp_ground_o, 1'b1);
        check(comp_boost_o, 1'b0);
        check(gate_drive_out_o, 1'b0);
        bus_read(qvs_pkg::REG_CTRL, d);
        check(d, 32'h1 << qvs_pkg::CTRL_EN_BIT);
        bus_read(qvs_pkg::REG_IRQ_EN, d);
        check(d, 32'h0);
        bus_read(8'hFC, d);
        check(d, 32'h0);
        @(posedge mclk_i);
        run_ok_i <= 1'b1;
        cycles(5);
        check(comp_ground_o, 1'b0);
        check(comp_boost_o, 1'b1);
        @(posedge mclk_i);
        ota_sinking_i <= 1'b1;
        cycles(4);
        check(comp_boost_o, 1'b0);
        foreach (rows[i]) begin
            @(posedge mclk_i);
            far_mode <= rows[i].mode;
            line_above_high_i <= rows[i].high;
            line_below_low_i <= !rows[i].high;
            // First period after a change is mixed, so skip it
            wait_gate(1'b1, n);
            wait_gate(1'b0, n);
            count_ground(g_fall);
            wait_gate(1'b1, t_off);
            count_ground(g_rise);
            wait_gate(1'b0, t_on);
            check(high_line_flag_o, rows[i].high);
            check(gain_half_o, rows[i].high);
            check(g_fall, 32'(qvs_pkg::FALL_GROUND_CYC));
            check(g_rise, 32'(qvs_pkg::RISE_GROUND_CYC));
            t_off += g_fall;
            t_on += g_rise;
            check(32'(t_off >= rows[i].lo && t_off < rows[i].lo + 10), 32'h1);
            check(32'(t_on >= 20 && t_on < 30), 32'h1);
        end
        @(posedge mclk_i);
        far_mode <= 2'h0;
        bus_read(qvs_pkg::REG_IRQ_STAT, d);
        check(d[qvs_pkg::IRQ_WATCHDOG], 1'b1);
        check(d[qvs_pkg::IRQ_TIMEOUT], 1'b1);
        check(irq_o, 1'b0);
        bus_write(qvs_pkg::REG_IRQ_EN, 32'h1 << qvs_pkg::IRQ_WATCHDOG);
        cycles(1);
        check(irq_o, 1'b1);
        bus_write(qvs_pkg::REG_IRQ_CLR, 32'h1F);
        cycles(1);
        check(irq_o, 1'b0);
        @(posedge mclk_i);
        line_above_high_i <= 1'b0;
        line_below_low_i <= 1'b1;
        cycles(90);
        check(high_line_flag_o, 1'b1);
        cycles(20);
        check(high_line_flag_o, 1'b0);
        check(gain_half_o, 1'b0);
        @(posedge mclk_i);
        line_above_high_i <= 1'b1;
        line_below_low_i <= 1'b0;
        cycles(4);
        check(high_line_flag_o, 1'b1);
        bus_read(qvs_pkg::REG_STATUS, d);
        check(d[qvs_pkg::STAT_HIGH_BIT], 1'b1);
        check(d[qvs_pkg::STAT_RUN_BIT], 1'b1);
        bus_read(qvs_pkg::REG_IRQ_STAT, d);
        check(d[qvs_pkg::IRQ_LOW], 1'b1);
        check(d[qvs_pkg::IRQ_HIGH], 1'b1);
        bus_write(qvs_pkg::REG_IRQ_EN, 32'h1 << qvs_pkg::IRQ_FAULT);
        @(posedge mclk_i);
        far_mode <= 2'h2;
        n = 0;
        while (comp_ground_o !== 1'b1 && n < 8000) begin
            cycles(1);
            n++;
        end
        check(32'(n < 8000), 32'h1);
        n = 0;
        t_on = 0;
        while (comp_ground_o === 1'b1 && n < 1000) begin
            t_on += int'(gate_drive_out_o !== 1'b0);
            cycles(1);
            n++;
        end
        check(t_on, 32'h0);
        check(32'(n >= 300 && n < 306), 32'h1);
        check(irq_o, 1'b1);
        @(posedge mclk_i);
        run_ok_i <= 1'b0;
        cycles(4);
        check(comp_ground_o, 1'b1);
        check(gate_drive_out_o, 1'b0);
        end_of_test();
    end

    // A hang counts as a failure
    initial begin : watchdog
        repeat (60000) @(posedge mclk_i);
        n_errors++;
        end_of_test();
    end
endmodule : testbench
